// ==== src/pmt_div_counter.sv ====
/*
 * Clearable divide-by-N counter used for prescaler and postscaler.
 * Assumes the clear and advance inputs come from the same clock domain.
 */
module pmt_div_counter #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control
    input  wire logic             clear,
    input  wire logic             advance,
    input  wire logic [WIDTH-1:0] last,
    // Result
    output logic                  wrap
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             wrap;
    } pmt_div_state_type;

    pmt_div_state_type state_ff;
    pmt_div_state_type nxt_state;

    always_comb begin
        nxt_state      = state_ff;
        nxt_state.wrap = 1'b0;
        if (clear) begin
            nxt_state.cnt = '0;
        end else if (advance) begin
            if (state_ff.cnt >= last) begin
                nxt_state.cnt  = '0;
                nxt_state.wrap = 1'b1;
            end else begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wrap = state_ff.wrap;

endmodule

// ==== src/pmt_pkg.sv ====
/*
 * Package for the 8-bit period-match timer: register offsets, field
 * positions, reset values and the shared carrier structs.
 * Assumes a 32-bit APB slave; each register takes one aligned word.
 */
package pmt_pkg;

    // Register byte offsets
    localparam logic [7:0] PMT_OFS_CONTROL  = 8'h00;
    localparam logic [7:0] PMT_OFS_COUNT    = 8'h04;
    localparam logic [7:0] PMT_OFS_PERIOD   = 8'h08;
    localparam logic [7:0] PMT_OFS_FLAG     = 8'h0C;
    localparam logic [7:0] PMT_OFS_ENABLE   = 8'h10;
    localparam logic [7:0] PMT_OFS_PRIORITY = 8'h14;

    // Control field positions and the match bit of flag, enable and priority
    localparam int PMT_CTL_PRE_LSB  = 0;
    localparam int PMT_CTL_RUN_BIT  = 2;
    localparam int PMT_CTL_POST_LSB = 3;
    localparam int PMT_MATCH_BIT    = 1;

    // Reset values
    localparam logic [6:0] PMT_RST_CONTROL  = 7'h00;
    localparam logic [7:0] PMT_RST_COUNT    = 8'h00;
    localparam logic [7:0] PMT_RST_PERIOD   = 8'hFF;
    localparam logic       PMT_RST_ENABLE   = 1'h0;
    localparam logic       PMT_RST_PRIORITY = 1'h1;

    // Base clock divide of the instruction clock
    localparam logic [1:0] PMT_OSC_DIV_LAST = 2'h3;

    // APB request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pmt_apb_req_type;

    // Timer events to neighbours
    typedef struct packed {
        logic match_raw;
        logic match_int;
        logic match_int_priority;
    } pmt_event_type;

endpackage

// ==== src/pmt_timer.sv ====
/*
 * 8-bit period-match timer with prescaler, postscaler, match flag and
 * APB register access.
 * Assumes a synchronous APB master on pclk; outputs go to the serial
 * port shift logic, the PWM generator and the interrupt controller.
 */

module pmt_timer (
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave
    input  wire pmt_pkg::pmt_apb_req_type apb_req,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Timer events
    output pmt_pkg::pmt_event_type        timer_event,
    output logic [7:0]                    count_value
);
    import pmt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [6:0]  control;
        logic [7:0]  count;
        logic [7:0]  period;
        logic        match_flag;
        logic        match_int_enable;
        logic        match_int_priority;
        logic [1:0]  osc_div;
        logic        match_raw;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        match_int;
    } pmt_state_type;

    pmt_state_type state_ff;
    pmt_state_type nxt_state;

    logic        apb_setup;
    logic        apb_access;
    logic        wr_hit;
    logic        wr_control;
    logic        wr_count;
    logic        timer_run;
    logic        base_tick;
    logic        pre_wrap;
    logic        post_wrap;
    logic        scaler_clear;
    logic [3:0]  pre_last;
    logic [3:0]  post_last;
    logic [31:0] rd_mux;
    logic        addr_ok;

    ////////////////////////////////////////////////////////////////////////
    // No wait state: answer in the first access cycle after setup
    assign apb_setup  = apb_req.psel && !apb_req.penable;
    assign apb_access = apb_req.psel && apb_req.penable;
    assign wr_hit     = apb_access && state_ff.pready && apb_req.pwrite;
    assign wr_control = wr_hit && (apb_req.paddr == PMT_OFS_CONTROL);
    assign wr_count   = wr_hit && (apb_req.paddr == PMT_OFS_COUNT);

    assign timer_run = state_ff.control[PMT_CTL_RUN_BIT];

    // instruction clock is pclk over four
    assign base_tick = timer_run && (state_ff.osc_div == PMT_OSC_DIV_LAST);

    always_comb begin
        case (state_ff.control[PMT_CTL_PRE_LSB +: 2])
            2'h0:    pre_last = 4'h0;
            2'h1:    pre_last = 4'h3;
            default: pre_last = 4'hF;
        endcase
    end

    // postscale ratio is code plus one
    assign post_last = state_ff.control[PMT_CTL_POST_LSB +: 4];

    // scaler clear on count or control write
    assign scaler_clear = wr_count || wr_control;

    pmt_div_counter #(
        .WIDTH (4)
    ) u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (scaler_clear),
        .advance (base_tick),
        .last    (pre_last),
        .wrap    (pre_wrap)
    );

    pmt_div_counter #(
        .WIDTH (4)
    ) u_postscaler (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (scaler_clear),
        .advance (state_ff.match_raw),
        .last    (post_last),
        .wrap    (post_wrap)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        addr_ok = 1'b1;
        case (apb_req.paddr)
            PMT_OFS_CONTROL:  rd_mux = {24'h0, 1'b0, state_ff.control};
            PMT_OFS_COUNT:    rd_mux = {24'h0, state_ff.count};
            PMT_OFS_PERIOD:   rd_mux = {24'h0, state_ff.period};
            PMT_OFS_FLAG:     rd_mux = {30'h0, state_ff.match_flag, 1'b0};
            PMT_OFS_ENABLE:   rd_mux = {30'h0, state_ff.match_int_enable, 1'b0};
            PMT_OFS_PRIORITY: rd_mux = {30'h0, state_ff.match_int_priority, 1'b0};
            default: begin
                rd_mux  = 32'h0;
                addr_ok = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state           = state_ff;
        nxt_state.match_raw = 1'b0;
        nxt_state.pready    = apb_setup;
        nxt_state.pslverr   = 1'b0;
        if (apb_setup) begin
            nxt_state.prdata  = apb_req.pwrite ? 32'h0 : rd_mux;
            nxt_state.pslverr = !addr_ok;
        end

        // free divide by four while running
        if (!timer_run) begin
            nxt_state.osc_div = 2'h0;
        end else begin
            nxt_state.osc_div = state_ff.osc_div + 2'h1;
        end

        // count up, wrap after period match
        // A pending tick is dropped on a count or control write
        if (pre_wrap && timer_run && !scaler_clear) begin
            if (state_ff.count == state_ff.period) begin
                nxt_state.count     = PMT_RST_COUNT;
                nxt_state.match_raw = 1'b1;
            end else begin
                nxt_state.count = state_ff.count + 8'h01;
            end
        end

        if (wr_hit) begin
            case (apb_req.paddr)
                PMT_OFS_CONTROL:  nxt_state.control = apb_req.pwdata[6:0];
                PMT_OFS_COUNT:    nxt_state.count = apb_req.pwdata[7:0];
                PMT_OFS_PERIOD:   nxt_state.period = apb_req.pwdata[7:0];
                PMT_OFS_FLAG:     nxt_state.match_flag = apb_req.pwdata[PMT_MATCH_BIT];
                PMT_OFS_ENABLE:
                    nxt_state.match_int_enable = apb_req.pwdata[PMT_MATCH_BIT];
                PMT_OFS_PRIORITY:
                    nxt_state.match_int_priority = apb_req.pwdata[PMT_MATCH_BIT];
                default: begin
                end
            endcase
        end
        if (wr_control) begin
            nxt_state.osc_div = 2'h0;
        end

        if (post_wrap) begin
            nxt_state.match_flag = 1'b1;
        end
        nxt_state.match_int = nxt_state.match_flag && nxt_state.match_int_enable;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff                    <= '0;
            state_ff.control            <= PMT_RST_CONTROL;
            state_ff.count              <= PMT_RST_COUNT;
            state_ff.period             <= PMT_RST_PERIOD;
            state_ff.match_int_enable   <= PMT_RST_ENABLE;
            state_ff.match_int_priority <= PMT_RST_PRIORITY;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // raw match to serial port and PWM
    assign timer_event.match_raw          = state_ff.match_raw;
    assign timer_event.match_int          = state_ff.match_int;
    assign timer_event.match_int_priority = state_ff.match_int_priority;
    assign count_value                    = state_ff.count;
    assign prdata                         = state_ff.prdata;
    assign pready                         = state_ff.pready;
    assign pslverr                        = state_ff.pslverr;

    ////////////////////////////////////////////////////////////////////////
    AST_WRAP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff.match_raw |-> state_ff.count == 8'h00)
        else $error("count not zero after match");

    AST_MATCH_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff.match_raw |-> $past(state_ff.count) == $past(state_ff.period)
            || $past(wr_hit))
        else $error("match without period equality");

    AST_RAW_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff.match_raw |=> !state_ff.match_raw)
        else $error("raw match wider than one cycle");

    AST_STOP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (!timer_run && !wr_hit) |=> state_ff.count == $past(state_ff.count))
        else $error("count moved while stopped");

    AST_CTL_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        wr_control |=> state_ff.count == $past(state_ff.count))
        else $error("control write changed count");

    AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        post_wrap |=> state_ff.match_flag)
        else $error("postscaled match did not set flag");

    AST_BIT7_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && apb_req.paddr == PMT_OFS_CONTROL) |-> prdata[7] == 1'b0)
        else $error("control bit 7 read nonzero");

    AST_INT_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        timer_event.match_int |-> state_ff.match_int_enable && state_ff.match_flag)
        else $error("interrupt without enable and flag");

    AST_DIV_FOUR: assert property (@(posedge pclk) disable iff (!presetn)
        base_tick |=> !base_tick [*3])
        else $error("base tick faster than quarter rate");

    AST_PRE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_count |=> !pre_wrap)
        else $error("prescaler wrapped right after count write");

    ////////////////////////////////////////////////////////////////////////
    AST_COUNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        (pre_wrap && timer_run && !scaler_clear && state_ff.count != state_ff.period)
            |=> state_ff.count == $past(state_ff.count) + 8'h01)
        else $error("count did not step on tick");

    AST_MATCH_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
        (pre_wrap && timer_run && !scaler_clear && state_ff.count == state_ff.period)
            |=> state_ff.match_raw)
        else $error("period match did not pulse");

    AST_RAW_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff.match_raw |-> $past(pre_wrap))
        else $error("raw match without prescaled tick");

    AST_PRE_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        (base_tick && pre_last == 4'h0 && !scaler_clear) |=> pre_wrap)
        else $error("prescale 1 did not pass the base tick");

    AST_STOP_PRE: assert property (@(posedge pclk) disable iff (!presetn)
        !timer_run |=> !pre_wrap)
        else $error("prescaler ticked while stopped");

    AST_POST_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        scaler_clear |=> !post_wrap)
        else $error("postscaler wrapped right after clear");

    AST_POST_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff.match_raw && post_last == 4'h0 && !scaler_clear) |=> post_wrap)
        else $error("postscale 1 did not pass the match");

    AST_CNT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_count |=> state_ff.count == $past(apb_req.pwdata[7:0]))
        else $error("count write did not land");

    AST_PER_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_hit && apb_req.paddr == PMT_OFS_PERIOD)
            |=> state_ff.period == $past(apb_req.pwdata[7:0]))
        else $error("period write did not land");

    AST_CTL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_control |=> state_ff.control == $past(apb_req.pwdata[6:0]))
        else $error("control write did not land");

    AST_FLAG_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_hit && apb_req.paddr == PMT_OFS_FLAG && !post_wrap)
            |=> state_ff.match_flag == $past(apb_req.pwdata[PMT_MATCH_BIT]))
        else $error("flag write did not land");

    AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff.match_flag && !(wr_hit && apb_req.paddr == PMT_OFS_FLAG))
            |=> state_ff.match_flag)
        else $error("flag dropped without a write");

    AST_FLAG_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_ff.match_flag)
            |-> $past(post_wrap) || $past(wr_hit && apb_req.paddr == PMT_OFS_FLAG))
        else $error("flag set without cause");

    AST_ENA_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_hit && apb_req.paddr == PMT_OFS_ENABLE)
            |=> state_ff.match_int_enable == $past(apb_req.pwdata[PMT_MATCH_BIT]))
        else $error("enable write did not land");

    AST_PRI_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_hit && apb_req.paddr == PMT_OFS_PRIORITY)
            |=> state_ff.match_int_priority == $past(apb_req.pwdata[PMT_MATCH_BIT]))
        else $error("priority write did not land");

    AST_INT_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff.match_flag && state_ff.match_int_enable) |-> timer_event.match_int)
        else $error("enabled flag gave no interrupt");

    AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready wider than one cycle");

    AST_ERR_READY: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr without pready");

    AST_PRDATA_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:8] == 24'h0)
        else $error("read data above the byte nonzero");

endmodule

// ==== testbench/pmt_far_side.sv ====
/*
 * Far-side model: serial port shift logic and PWM generator listener.
 * Assumes match_raw is a one-cycle pulse in the pclk domain.
 */
module pmt_far_side
    import pmt_pkg::*;
(
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // Timer events
    input  wire pmt_pkg::pmt_event_type ev,
    // Observations
    output logic [15:0]                 shift_cnt,
    output logic [15:0]                 pwm_gap
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] run_len;

    ////////////////////////////////////////////////////////////////////////////
    // shift clock, PWM period
    // Gap is edge to edge, so a stuck pulse reads as period 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_cnt <= 16'h0;
            pwm_gap   <= 16'h0;
            run_len   <= 16'h0;
        end else if (ev.match_raw) begin
            shift_cnt <= shift_cnt + 16'h1;
            pwm_gap   <= run_len + 16'h1;
            run_len   <= 16'h0;
        end else begin
            run_len <= run_len + 16'h1;
        end
    end
endmodule

// ==== testbench/pmt_timer_tb.sv ====
/*
 * Self-checking bench for the period-match timer over APB.
 * Assumes the far-side model counts raw matches and their spacing.
 */
module pmt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pmt_pkg::*;

    logic            pclk;
    logic            presetn;
    pmt_apb_req_type req;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    pmt_event_type   tev;
    logic [7:0]      count_value;
    logic [15:0]     shift_cnt;
    logic [15:0]     pwm_gap;
    logic [31:0]     rd_data;
    logic            rd_err;
    logic [15:0]     base;
    int              err_total;
    int              checked;
    int              n;
    logic [3:0]      n_codes [3] = '{4'h0, 4'h2, 4'hF};

    pmt_timer dut (
        .pclk        (pclk),
        .presetn     (presetn),
        .apb_req     (req),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .timer_event (tev),
        .count_value (count_value)
    );

    pmt_far_side far (
        .pclk      (pclk),
        .presetn   (presetn),
        .ev        (tev),
        .shift_cnt (shift_cnt),
        .pwm_gap   (pwm_gap)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) err_total++;
        rd_data = prdata;
        rd_err  = pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_data, exp);
    endtask

    task automatic restart(input logic [7:0] ctl);
        wr(PMT_OFS_CONTROL, 8'h00);
        wr(PMT_OFS_COUNT, 8'h00);
        wr(PMT_OFS_FLAG, 8'h00);
        wr(PMT_OFS_CONTROL, ctl);
    endtask

    task automatic wait_matches(input int m);
        base = shift_cnt;
        n = 0;
        while (shift_cnt < base + 16'(m) && n < 3000) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 3000) err_total++;
    endtask

    task automatic test_done;
        $display("mismatches %0d, comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        test_done();
    end

    initial begin
        err_total = 0;
        checked   = 0;
        req       = '0;
        presetn   = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(PMT_OFS_CONTROL, 32'h00);
        rd(PMT_OFS_COUNT, 32'h00);
        chk({24'h0, count_value}, 32'h00);
        rd(PMT_OFS_PERIOD, 32'hFF);
        rd(PMT_OFS_ENABLE, 32'h00);
        rd(PMT_OFS_PRIORITY, 32'h02);
        chk({31'h0, tev.match_int_priority}, 32'h1);
        wr(PMT_OFS_PERIOD, 8'hA5);
        rd(PMT_OFS_PERIOD, 32'hA5);
        wr(PMT_OFS_COUNT, 8'h5A);
        rd(PMT_OFS_COUNT, 32'h5A);
        repeat (40) @(posedge pclk);
        rd(PMT_OFS_COUNT, 32'h5A);
        chk({24'h0, count_value}, 32'h5A);
        wr(PMT_OFS_CONTROL, 8'h7B);
        rd(PMT_OFS_COUNT, 32'h5A);
        wr(PMT_OFS_CONTROL, 8'hFF);
        rd(PMT_OFS_CONTROL, 32'h7F);
        apb(1'b0, 8'h18, 32'h0);
        chk({rd_err, rd_data[30:0]}, 32'h80000000);
        wr(PMT_OFS_PERIOD, 8'h02);
        // Period 3 ticks of four pclk cycles times the prescale
        for (int p = 0; p < 4; p++) begin
            restart(8'h04 | 8'(p));
            wait_matches(3);
            chk(32'(pwm_gap), 32'(12 * (p == 0 ? 1 : (p == 1 ? 4 : 16))));
        end
        // Count write mid-prescale restarts the divide by 16
        restart(8'h07);
        repeat (40) @(posedge pclk);
        wr(PMT_OFS_COUNT, 8'h00);
        repeat (48) @(posedge pclk);
        rd(PMT_OFS_COUNT, 32'h00);
        wr(PMT_OFS_ENABLE, 8'h02);
        foreach (n_codes[i]) begin
            restart({1'b0, n_codes[i], 3'h4});
            base = shift_cnt;
            n = 0;
            while (tev.match_int !== 1'b1 && n < 3000) begin
                @(negedge pclk);
                n++;
            end
            chk(32'(shift_cnt - base), 32'(n_codes[i]) + 32'h1);
            rd(PMT_OFS_FLAG, 32'h02);
        end
        wr(PMT_OFS_ENABLE, 8'h00);
        repeat (3) @(posedge pclk);
        chk({31'h0, tev.match_int}, 32'h0);
        // Second reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(PMT_OFS_COUNT, 32'h00);
        rd(PMT_OFS_PERIOD, 32'hFF);
        rd(PMT_OFS_CONTROL, 32'h00);
        test_done();
    end
endmodule
